/* core/msc_stats.sv */
// Top of the MAC statistics counter block: counters, dump engine, byte count, flow control
//
// The placing of the registers and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
// Contract
// RULE_01: Counters update only when a frame's transmit or receive finishes.
// RULE_02: Dump or dump-and-reset command in command field makes counters be written out.
// RULE_03: Offset 0 counts good transmitted frames, after wire transmission ends.
// RULE_04: Offset 4 counts frames aborted at maximum collision count.
// RULE_05: Offset 8 counts frames aborted by late collision.
// RULE_06: Offset 12 counts underrun drops or retries, possibly several per frame.
// RULE_07: Offset 16 counts frames sent while carrier sense dropped.
// RULE_08: Offset 20 counts frames deferred by a busy link.
// RULE_09: Offset 24 counts good frames with exactly one collision.
// RULE_10: Offset 28 counts good frames with two or more collisions.
// RULE_11: Offset 32 accumulates all transmit collisions, late and maximum included.
// RULE_12: Offset 36 counts good received frames after all bytes stored.
// RULE_13: Offset 40 counts aligned frames discarded for CRC mismatch.
// RULE_14: CRC error counter updates regardless of receive unit state.
// RULE_15: CRC, alignment and short-frame errors are mutually exclusive.
// RULE_16: Keep a running count of receive bytes moved to host memory.
// RULE_17: Flow-control register holds pause/on/off command and free-byte threshold.
// RULE_18: Each counter is 32 bits and wraps to zero.
// RULE_19: Reset clears all counters; software cannot preset them.
// RULE_20: One frame may update several counters; all are applied.
// RULE_21: Dump-and-reset clears each counter right after capturing it, losing nothing.
module msc_stats #(
   parameter int unsigned COL_W = 5
) (
   input  wire logic                 clock,
   input  wire logic                 resetn,
   // Register port
   input  wire logic [7:0]           reg_addr,
   input  wire logic [31:0]          reg_wdata,
   input  wire logic                 reg_wr,
   input  wire logic                 reg_rd,
   output logic [31:0]               reg_rdata,
   // Transmit frame completion report
   input  wire logic                 tx_done,
   input  wire logic                 tx_ok,
   input  wire logic                 tx_max_collision_abort,
   input  wire logic                 tx_late_collision_abort,
   input  wire logic                 tx_lost_crs,
   input  wire logic                 tx_deferred,
   input  wire logic [COL_W-1:0]     tx_collisions,
   input  wire logic                 tx_underrun,
   // Receive frame completion report
   input  wire logic                 rx_done,
   input  wire logic                 rx_ok,
   input  wire logic                 rx_crc_err,
   input  wire logic                 rx_misaligned,
   input  wire logic                 rx_short,
   input  wire logic                 rx_dma_valid,
   input  wire logic [2:0]           rx_dma_bytes,
   // Host memory write port for the dump
   input  wire logic                 mem_ready,
   output logic                      mem_wr,
   output logic [31:0]               mem_addr,
   output logic [31:0]               mem_wdata,
   // Flow-control settings to the MAC
   output logic [msc_pkg::FC_CMD_W-1:0] fc_cmd,
   output logic [msc_pkg::FC_THR_W-1:0] fc_threshold
);
   import msc_pkg::*;

   // =====================================================
   // Register decode
   wire         wr_cmd     = reg_wr && (reg_addr == REG_CMD);
   wire         wr_flow    = reg_wr && (reg_addr == REG_FLOWCTL);
   wire         wr_dump_ad = reg_wr && (reg_addr == REG_DUMP_AD);
   wire  [3:0]  cu_cmd     = reg_wdata[3:0];
   wire         cmd_dump   = wr_cmd && ((cu_cmd == CU_CMD_DUMP) || (cu_cmd == CU_CMD_DUMP_RESET));  // RULE_02

   // =====================================================
   // Increment conditions, all applied together for one frame
   logic [NUM_CNT-1:0] inc;
   wire  one_col   = (tx_collisions == COL_W'(1));
   wire  multi_col = (tx_collisions > COL_W'(1));
   wire  crc_only  = rx_crc_err && !rx_misaligned && !rx_short;                         // RULE_15
   assign inc[C_TX_GOOD]  = tx_done && tx_ok;                                           // RULE_01 RULE_03
   assign inc[C_MAX_COLL]  = tx_done && tx_max_collision_abort;                         // RULE_04
   assign inc[C_LATE_COLL] = tx_done && tx_late_collision_abort;                        // RULE_05
   // Underrun is reported per attempt, so a retried frame can count more than once
   assign inc[C_UNDERRUN] = tx_done && tx_underrun;                                     // RULE_06
   assign inc[C_LOSTCRS]  = tx_done && tx_ok && tx_lost_crs;                            // RULE_07
   assign inc[C_DEFER]    = tx_done && tx_deferred;                                     // RULE_08
   assign inc[C_SCOL]     = tx_done && tx_ok && one_col;                                // RULE_09
   assign inc[C_MCOL]     = tx_done && tx_ok && multi_col;                              // RULE_10
   assign inc[C_TCOL]     = tx_done && (tx_collisions != '0);                           // RULE_11
   assign inc[C_RX_GOOD]  = rx_done && rx_ok;                                           // RULE_01 RULE_12
   // No receive-unit state gates this one: a CRC error is counted in any state
   assign inc[C_RX_CRC]   = rx_done && crc_only;                                        // RULE_13 RULE_14

   // Total-collision counter adds a frame's whole collision count, not just one
   logic [CNT_W-1:0] tcol_q;

   // =====================================================
   // Dump sequencer
   logic               dump_busy;
   logic               dump_adv;
   logic [IDX_W-1:0]   dump_idx;
   logic               dump_last;
   logic               reset_mode_q;
   logic               done_q;
   logic [31:0]        dump_base_q;

   msc_dump #(
      .N  (NUM_CNT),
      .IW (IDX_W)
   ) u_dump (
      .clock     (clock),
      .resetn    (resetn),
      .start     (cmd_dump && !dump_busy),
      .mem_ready (mem_ready),
      .busy      (dump_busy),
      .advance   (dump_adv),
      .idx       (dump_idx),
      .last      (dump_last)
   );

   // =====================================================
   // Counter bank
   logic [CNT_W-1:0] cnt_val [NUM_CNT];
   genvar gi;
   generate
      for (gi = 0; gi < NUM_CNT; gi++) begin : g_cnt
         if (gi != C_TCOL) begin : g_plain
            msc_counter #(
               .W (CNT_W)
            ) u_cnt (
               .clock  (clock),
               .resetn (resetn),
               .inc    (inc[gi]),
               .clr    (dump_adv && reset_mode_q && (dump_idx == IDX_W'(gi))),  // RULE_21
               .value  (cnt_val[gi])
            );
         end else begin : g_total
            assign cnt_val[gi] = tcol_q;
         end
      end
   endgenerate

   // Total collisions: capture-and-clear keeps the same-cycle addition
   wire  tcol_clr = dump_adv && reset_mode_q && (dump_idx == C_TCOL);
   wire  [CNT_W-1:0] tcol_add = inc[C_TCOL] ? CNT_W'(tx_collisions) : '0;
   wire  [CNT_W-1:0] tcol_d   = tcol_clr ? tcol_add : (tcol_q + tcol_add);            // RULE_11 RULE_18 RULE_20
   always_ff @(posedge clock) begin
      if (!resetn) tcol_q <= CNT_RST;                                                   // RULE_19
      else         tcol_q <= tcol_d;
   end

   // =====================================================
   // Dump control registers
   always_ff @(posedge clock) begin
      if (!resetn) begin
         reset_mode_q <= 1'b0;
         done_q       <= 1'b0;
         dump_base_q  <= 32'h0000_0000;
      end else begin
         if (cmd_dump && !dump_busy) reset_mode_q <= (cu_cmd == CU_CMD_DUMP_RESET);    // RULE_02
         // Done is set when the last word leaves; a new command clears it
         if (dump_last)             done_q <= 1'b1;
         else if (cmd_dump)         done_q <= 1'b0;
         if (wr_dump_ad)            dump_base_q <= reg_wdata;
      end
   end

   // Memory write stream, registered so the outputs come from flops
   wire [31:0] word_addr = dump_base_q + {26'h0, dump_idx, 2'h0};
   always_ff @(posedge clock) begin
      if (!resetn) begin
         mem_wr    <= 1'b0;
         mem_addr  <= 32'h0000_0000;
         mem_wdata <= 32'h0000_0000;
      end else begin
         mem_wr    <= dump_adv;                                                         // RULE_02
         mem_addr  <= word_addr;
         mem_wdata <= cnt_val[dump_idx];
      end
   end

   // =====================================================
   // Receive DMA byte count, wraps like the counters
   logic [31:0] rx_bytes_q;
   always_ff @(posedge clock) begin
      if (!resetn)           rx_bytes_q <= 32'h0000_0000;
      else if (rx_dma_valid) rx_bytes_q <= rx_bytes_q + {29'h0, rx_dma_bytes};         // RULE_16
   end

   // =====================================================
   // Flow-control register
   always_ff @(posedge clock) begin
      if (!resetn) begin
         fc_cmd       <= FC_CMD_RST;
         fc_threshold <= FC_THR_RST;
      end else if (wr_flow) begin
         fc_cmd       <= reg_wdata[FC_CMD_LSB +: FC_CMD_W];                            // RULE_17
         fc_threshold <= reg_wdata[FC_THR_W-1:0];                                       // RULE_17
      end
   end

   // =====================================================
   // Read path; counters are not mapped, software sees them only through the dump
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (reg_addr)
         REG_STATUS:  rd_mux = {30'h0, done_q, dump_busy};
         REG_RXBYTES: rd_mux = rx_bytes_q;
         REG_FLOWCTL: rd_mux = {14'h0, fc_cmd, fc_threshold};
         REG_DUMP_AD: rd_mux = dump_base_q;
         default:     rd_mux = 32'h0000_0000;
      endcase
   end
   always_ff @(posedge clock) begin
      if (!resetn)     reg_rdata <= 32'h0000_0000;
      else if (reg_rd) reg_rdata <= rd_mux;
      else             reg_rdata <= 32'h0000_0000;
   end
endmodule : msc_stats

/* core/msc_pkg.sv */
// Package of constants and types for the MAC statistics counter block
package msc_pkg;
   // =====================================================
   // Counter layout
   localparam int unsigned CNT_W       = 32;
   localparam int unsigned NUM_CNT     = 11;
   localparam int unsigned IDX_W       = 4;
   localparam logic [7:0]  OFF_TX_GOOD = 8'h00;
   localparam logic [7:0]  OFF_MAX_COLL  = 8'h04;
   localparam logic [7:0]  OFF_LATE_COLL = 8'h08;
   localparam logic [7:0]  OFF_UNDERRUN= 8'h0C;
   localparam logic [7:0]  OFF_LOSTCRS = 8'h10;
   localparam logic [7:0]  OFF_DEFER   = 8'h14;
   localparam logic [7:0]  OFF_SCOL    = 8'h18;
   localparam logic [7:0]  OFF_MCOL    = 8'h1C;
   localparam logic [7:0]  OFF_TCOL    = 8'h20;
   localparam logic [7:0]  OFF_RX_GOOD = 8'h24;
   localparam logic [7:0]  OFF_RX_CRC  = 8'h28;
   // Counter indices (offset / 4)
   localparam logic [IDX_W-1:0] C_TX_GOOD  = 4'h0;
   localparam logic [IDX_W-1:0] C_MAX_COLL  = 4'h1;
   localparam logic [IDX_W-1:0] C_LATE_COLL = 4'h2;
   localparam logic [IDX_W-1:0] C_UNDERRUN = 4'h3;
   localparam logic [IDX_W-1:0] C_LOSTCRS  = 4'h4;
   localparam logic [IDX_W-1:0] C_DEFER    = 4'h5;
   localparam logic [IDX_W-1:0] C_SCOL     = 4'h6;
   localparam logic [IDX_W-1:0] C_MCOL     = 4'h7;
   localparam logic [IDX_W-1:0] C_TCOL     = 4'h8;
   localparam logic [IDX_W-1:0] C_RX_GOOD  = 4'h9;
   localparam logic [IDX_W-1:0] C_RX_CRC   = 4'hA;
   // =====================================================
   // Register map of this block
   localparam logic [7:0]  REG_CMD     = 8'h40;  // Command unit command field, bits 3:0
   localparam logic [7:0]  REG_STATUS  = 8'h44;  // Bit 0 dump busy, bit 1 dump done
   localparam logic [7:0]  REG_RXBYTES = 8'h48;  // Receive DMA byte count
   localparam logic [7:0]  REG_FLOWCTL = 8'h4C;  // Flow-control command and threshold
   localparam logic [7:0]  REG_DUMP_AD = 8'h50;  // Dump base address in host memory
   localparam int unsigned FC_CMD_LSB  = 16;
   localparam int unsigned FC_CMD_W    = 2;
   localparam int unsigned FC_THR_W    = 16;
   localparam logic [FC_CMD_W-1:0] FC_CMD_RST = 2'h0;
   localparam logic [FC_THR_W-1:0] FC_THR_RST = 16'h0000;
   localparam logic [CNT_W-1:0]    CNT_RST    = 32'h0000_0000;
   // =====================================================
   // Command unit commands
   localparam logic [3:0]  CU_CMD_DUMP       = 4'h5;
   localparam logic [3:0]  CU_CMD_DUMP_RESET = 4'h7;
   typedef enum logic [1:0] {MSC_FC_OFF, MSC_FC_ON, MSC_FC_PAUSE, MSC_FC_RSVD} msc_fc_e;
endpackage : msc_pkg

/* core/msc_counter.sv */
// One wrap-around statistics counter with capture-and-clear support
`timescale 1ns/1ps
module msc_counter #(
   parameter int unsigned W = 32
) (
   input  wire logic         clock,
   input  wire logic         resetn,
   input  wire logic         inc,
   input  wire logic         clr,
   output logic [W-1:0]      value
);
   logic [W-1:0] cnt_q;
   logic [W-1:0] cnt_d;
   // =====================================================
   // Next value: clear drops the old count but keeps an increment of the same cycle
   assign cnt_d = clr ? {{(W-1){1'b0}}, inc} : (cnt_q + {{(W-1){1'b0}}, inc});  // RULE_18 RULE_21
   assign value = cnt_q;
   // Only reset, clear and wrap-around bring the count to zero; there is no preset path
   always_ff @(posedge clock) begin
      if (!resetn) cnt_q <= '0;  // RULE_19
      else         cnt_q <= cnt_d;
   end
endmodule : msc_counter

/* core/msc_dump.sv */
// Dump sequencer: walks the counters and emits one host-memory write per word
`timescale 1ns/1ps
module msc_dump #(
   parameter int unsigned N   = 11,
   parameter int unsigned IW  = 4
) (
   input  wire logic            clock,
   input  wire logic            resetn,
   input  wire logic            start,
   input  wire logic            mem_ready,
   output logic                 busy,
   output logic                 advance,
   output logic [IW-1:0]        idx,
   output logic                 last
);
   typedef enum logic [0:0] {MSC_D_IDLE, MSC_D_RUN} msc_dstate_e;
   msc_dstate_e st_q;
   logic [IW-1:0] idx_q;
   // =====================================================
   // Advance one word each time the memory side accepts it
   assign advance = (st_q == MSC_D_RUN) && mem_ready;
   assign last    = advance && (idx_q == IW'(N - 1));
   assign busy    = (st_q == MSC_D_RUN);
   assign idx     = idx_q;
   always_ff @(posedge clock) begin
      if (!resetn) begin
         st_q  <= MSC_D_IDLE;
         idx_q <= '0;
      end else begin
         unique case (st_q)
            MSC_D_IDLE: begin
               idx_q <= '0;
               if (start) st_q <= MSC_D_RUN;
            end
            MSC_D_RUN: begin
               if (last) st_q <= MSC_D_IDLE;
               else if (advance) idx_q <= idx_q + IW'(1);
            end
         endcase
      end
   end
endmodule : msc_dump

/* dv/msc_asserts.sv */
// Port-level checker for the statistics block
`timescale 1ns/1ps
module msc_asserts (
   input wire logic                clock,
   input wire logic                resetn,
   input wire logic [7:0]          reg_addr,
   input wire logic [31:0]         reg_wdata,
   input wire logic                reg_wr,
   input wire logic                reg_rd,
   input wire logic [31:0]         reg_rdata,
   input wire logic                mem_ready,
   input wire logic                mem_wr,
   input wire logic [31:0]         mem_addr,
   input wire logic [msc_pkg::FC_CMD_W-1:0] fc_cmd,
   input wire logic [msc_pkg::FC_THR_W-1:0] fc_threshold
);
   import msc_pkg::*;
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);
   logic [31:0] base_q;
   logic [4:0]  wcnt_q;
   // =====================================================
   // Decodes; a dump command issued while busy would upset the count, the bench never does that
   wire fc_wr = reg_wr && reg_addr == REG_FLOWCTL;
   wire go_wr = reg_wr && reg_addr == REG_CMD &&
                (reg_wdata[3:0] == CU_CMD_DUMP || reg_wdata[3:0] == CU_CMD_DUMP_RESET);
   // Shadow of the dump base and words written since the last dump command
   always_ff @(posedge clock) begin
      if (!resetn) begin
         base_q <= 32'h0000_0000;
         wcnt_q <= 5'h00;
      end else begin
         if (reg_wr && reg_addr == REG_DUMP_AD) base_q <= reg_wdata;
         if (go_wr) wcnt_q <= 5'h00;
         else if (mem_wr) wcnt_q <= wcnt_q + 5'h01;
      end
   end
   // =====================================================
   // Assertions
   rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0) else $error("read data outside slot");
   flow_read_a: assert property (reg_rd && reg_addr == REG_FLOWCTL |=>
      reg_rdata == {14'h0, fc_cmd, fc_threshold}) else $error("flow readback differs from pins");
   flow_write_a: assert property (fc_wr |=> fc_cmd == $past(reg_wdata[17:16]) &&
      fc_threshold == $past(reg_wdata[15:0])) else $error("flow write not applied");
   flow_hold_a: assert property (!fc_wr |=> $stable(fc_cmd) && $stable(fc_threshold))
      else $error("flow fields changed without write");
   dump_ready_a: assert property (mem_wr |-> $past(mem_ready)) else $error("dump word without ready");
   dump_addr_a: assert property (mem_wr |-> mem_addr == base_q + (32'(wcnt_q) << 2))
      else $error("dump word address out of order");
   dump_len_a: assert property (mem_wr |-> wcnt_q < 5'(NUM_CNT)) else $error("dump too long");
   unmapped_rd_a: assert property (reg_rd && reg_addr > REG_DUMP_AD |=> reg_rdata == 32'h0)
      else $error("unmapped read not zero");
endmodule : msc_asserts

/* dv/msc_mem_model.sv */
// Host memory model taking dump words, with optional back-pressure
`timescale 1ns/1ps
module msc_mem_model (
   input  wire logic        clock,
   input  wire logic        slow,
   input  wire logic        mem_wr,
   input  wire logic [31:0] mem_addr,
   input  wire logic [31:0] mem_wdata,
   output logic             mem_ready
);
   logic [1:0]  ph_q = 2'h0;
   logic [31:0] word [16];
   // Refuse one cycle in three when slow, so the dump engine must stall
   assign mem_ready = !slow || ph_q != 2'h0;
   // Words land by index within the dump area
   always @(posedge clock) begin
      ph_q <= (ph_q == 2'h2) ? 2'h0 : ph_q + 2'h1;
      if (mem_wr) word[mem_addr[5:2]] <= mem_wdata;
   end
endmodule : msc_mem_model

/* dv/msc_stats_tb_top.sv */
// Self-checking bench for the statistics block
`timescale 1ns/1ps
module msc_stats_tb_top;
   import msc_pkg::*;
   logic        clock = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, slow = 1'b0;
   logic        tx_done = 1'b0, rx_done = 1'b0, rx_dma_valid = 1'b0, mem_ready, mem_wr;
   logic [7:0]  reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0, reg_rdata, mem_addr, mem_wdata;
   logic [5:0]  txf = 6'h00;
   logic [4:0]  tx_col = 5'h00;
   logic [3:0]  rxf = 4'h0;
   logic [2:0]  rx_dma_bytes = 3'h0;
   logic [1:0]  fc_cmd;
   logic [15:0] fc_threshold;
   logic [31:0] ex [NUM_CNT] = '{default: 32'h0};
   int          err_count = 0, check_count = 0;
   always #5 clock = ~clock;
   msc_stats i_msc_stats (
      .clock(clock), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_done(tx_done), .tx_ok(txf[5]),
      .tx_max_collision_abort(txf[4]), .tx_late_collision_abort(txf[3]), .tx_lost_crs(txf[2]),
      .tx_deferred(txf[1]), .tx_collisions(tx_col), .tx_underrun(txf[0]), .rx_done(rx_done),
      .rx_ok(rxf[3]), .rx_crc_err(rxf[2]), .rx_misaligned(rxf[1]), .rx_short(rxf[0]),
      .rx_dma_valid(rx_dma_valid), .rx_dma_bytes(rx_dma_bytes), .mem_ready(mem_ready), .mem_wr(mem_wr),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata), .fc_cmd(fc_cmd), .fc_threshold(fc_threshold));
   msc_mem_model i_msc_mem_model (.clock(clock), .slow(slow), .mem_wr(mem_wr), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .mem_ready(mem_ready));
   // =====================================================
   // Bus tasks and comparison
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask : rd
   // Frame reports: qualifiers settle a cycle ahead, so early counting shows up
   task automatic tx(input logic [5:0] f, input logic [4:0] c);
      @(posedge clock);
      txf <= f;
      tx_col <= c;
      @(posedge clock);
      tx_done <= 1'b1;
      @(posedge clock);
      tx_done <= 1'b0;
      txf <= 6'h00;
      tx_col <= 5'h00;
      ex[C_TX_GOOD] += 32'(f[5]);
      ex[C_SCOL] += 32'(f[5] && c == 5'd1);
      ex[C_MCOL] += 32'(f[5] && c > 5'd1);
      ex[C_LOSTCRS] += 32'(f[5] && f[2]);
      ex[C_DEFER] += 32'(f[1]);
      ex[C_MAX_COLL] += 32'(f[4]);
      ex[C_LATE_COLL] += 32'(f[3]);
      ex[C_UNDERRUN] += 32'(f[0]);
      ex[C_TCOL] += 32'(c);
   endtask : tx
   task automatic rx(input logic [3:0] f);
      @(posedge clock);
      rxf <= f;
      @(posedge clock);
      rx_done <= 1'b1;
      @(posedge clock);
      rx_done <= 1'b0;
      rxf <= 4'h0;
      ex[C_RX_GOOD] += 32'(f[3]);
      ex[C_RX_CRC] += 32'(f[2] && !f[1] && !f[0]);
   endtask : rx
   // Dump and compare every word; a hung dump ends the run
   task automatic dump(input logic [3:0] cmd);
      logic [31:0] v;
      int          n;
      foreach (i_msc_mem_model.word[i]) i_msc_mem_model.word[i] = 32'hFFFF_FFFF;
      wr(REG_CMD, {28'h0, cmd});
      // Eleven words take at least eleven cycles, so the first poll must see busy
      rd(REG_STATUS, v);
      chk("dump busy", v, 32'h1);
      for (n = 0; n < 300 && v[1:0] !== 2'b10; n++) rd(REG_STATUS, v);
      if (v[1:0] !== 2'b10) begin
         err_count++;
         complete_run();
      end
      for (int i = 0; i < NUM_CNT; i++) chk($sformatf("dump word %0d", i), i_msc_mem_model.word[i], ex[i]);
      if (cmd == CU_CMD_DUMP_RESET) foreach (ex[i]) ex[i] = 32'h0;
   endtask : dump
   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : complete_run
   // =====================================================
   // Main sequence
   initial begin
      logic [31:0] v;
      repeat (12) @(posedge clock);
      resetn <= 1'b1;
      rd(REG_RXBYTES, v);
      chk("rx bytes reset", v, 32'h0);
      rd(8'h60, v);
      chk("unmapped read", v, 32'h0);
      wr(REG_DUMP_AD, 32'h0000_1000);
      rd(REG_DUMP_AD, v);
      chk("dump base", v, 32'h0000_1000);
      dump(CU_CMD_DUMP);
      for (int k = 0; k < 4; k++) begin
         wr(REG_FLOWCTL, {14'h0, 2'(k), 16'hA5C3 ^ 16'(k)});
         rd(REG_FLOWCTL, v);
         chk("flow register", v, {14'h0, 2'(k), 16'hA5C3 ^ 16'(k)});
         chk("flow cmd pin", {30'h0, fc_cmd}, 32'(k));
      end
      tx(6'b100000, 5'd0);
      tx(6'b100110, 5'd1);
      tx(6'b100000, 5'd3);
      tx(6'b010000, 5'd16);
      tx(6'b001000, 5'd1);
      tx(6'b000001, 5'd0);
      tx(6'b000001, 5'd0);
      rx(4'b1000);
      rx(4'b0100);
      rx(4'b0110);
      rx(4'b0101);
      @(posedge clock);
      rx_dma_valid <= 1'b1;
      rx_dma_bytes <= 3'd7;
      @(posedge clock);
      rx_dma_bytes <= 3'd3;
      @(posedge clock);
      rx_dma_valid <= 1'b0;
      rd(REG_RXBYTES, v);
      chk("rx bytes", v, 32'd10);
      slow <= 1'b1;
      dump(CU_CMD_DUMP_RESET);
      dump(CU_CMD_DUMP);
      slow <= 1'b0;
      tx(6'b100000, 5'd0);
      dump(CU_CMD_DUMP);
      complete_run();
   end
endmodule : msc_stats_tb_top
bind msc_stats msc_asserts i_msc_asserts (.clock(clock), .resetn(resetn), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_ready(mem_ready),
   .mem_wr(mem_wr), .mem_addr(mem_addr), .fc_cmd(fc_cmd), .fc_threshold(fc_threshold));
